// file: hdl/rsi_pkg.sv
// constants and types for the reset and supply integrity block
`default_nettype none

package rsi_pkg;
	// ========================================
	// clock and timing
	localparam int unsigned CLK_PERIOD_PS   = 10000;
	// least watchdog reset pin low time, in ns
	localparam int unsigned WDG_PULSE_NS    = 200;
	localparam int unsigned WDG_PULSE_CYC_I = (WDG_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned WDG_PULSE_CYC   = (WDG_PULSE_CYC_I < 1) ? 1 : WDG_PULSE_CYC_I;
	// reset delay phase, in cpu cycles
	localparam logic [12:0] DELAY_SHORT_CYC = 13'h0100;
	localparam logic [12:0] DELAY_LONG_CYC  = 13'h1000;
	localparam logic [1:0]  FETCH_CYC       = 2'h2;
	localparam logic [12:0] WDG_CNT_LOAD    = 13'(WDG_PULSE_CYC);

	// ========================================
	// register map
	localparam logic [7:0] SICS_OFFSET      = 8'h00;
	localparam logic [7:0] SICS_RESET       = 8'h00;
	localparam int unsigned BIT_IRQ_EN      = 6;
	localparam int unsigned BIT_AUX_FLAG    = 5;
	localparam int unsigned BIT_LV_CAUSE    = 4;
	localparam int unsigned BIT_WD_CAUSE    = 0;

	// ========================================
	// reset sequencer states
	typedef enum logic [1:0] {
		SEQ_ACTIVE = 2'b00,
		SEQ_DELAY  = 2'b01,
		SEQ_FETCH  = 2'b10,
		SEQ_RUN    = 2'b11
	} rsi_seq_t;
endpackage : rsi_pkg

`default_nettype wire

// file: hdl/rsi_top.sv
// reset sequencer, supply integrity register and aux detector interrupt
// How it works
// - reset pin is an input and an open-drain output with weak pull-up
// - external low on reset pin enters reset asynchronously, even when halted
// - low-voltage reset drives the reset pin low to reset other devices
// - reset held static while low-voltage detector reports supply below threshold
// - watchdog underflow drives reset pin low for at least the minimum time
// - option enables low-voltage detector and picks low, medium or high threshold
// - aux detector inactive unless low-voltage detector enabled by option
// - bit 5 reads aux comparator output live, 1 means supply low
// - with bit 6 set, each aux flag toggle raises an interrupt request
// - pending aux interrupt clears when the cpu enters its service routine
// - interrupt delivered only when enabled and cpu global mask is clear
// - supply rising within the reset delay gives no aux interrupt
// - enabling before upper crossing gives two interrupts, after it gives one
// - wait mode unaffected and aux interrupt wakes it; halt is not woken
// - halt freezes the control and status register
// - bit 4 set on low-voltage reset, software clears by writing zero
// - bit 0 set on watchdog reset, cleared by zero write or low-voltage reset
// - low-voltage cause survives later external or watchdog resets
// - after any active phase pin stays low 256 or 4096 cycles, then fetch
`timescale 1ns/1ps
`default_nettype none

module rsi_top (
	input  wire logic       I_SYS_CLK,         // cpu clock, 100 MHz
	input  wire logic       I_RST_N,           // power-on reset, async, low
	input  wire logic       I_PSEL,            // apb select
	input  wire logic       I_PENABLE,         // apb enable
	input  wire logic       I_PWRITE,          // apb direction, 1 write
	input  wire logic [7:0] I_PADDR,           // apb byte address
	input  wire logic [31:0] I_PWDATA,         // apb write data
	output logic      [31:0] O_PRDATA,         // apb read data
	output logic            O_PREADY,          // apb ready
	output logic            O_PSLVERR,         // apb error, unmapped address
	input  wire logic       I_RST_PIN_I,       // reset pin level
	output logic            O_RST_PIN_O,       // reset pin drive value, always 0
	output logic            O_RST_PIN_OE,      // reset pin pull-down enable
	input  wire logic       I_OPT_LVD_EN,      // option: low-voltage detector on
	input  wire logic [1:0] I_OPT_LVD_THR,     // option: threshold low/med/high
	input  wire logic       I_OPT_LONG_DELAY,  // option: 4096 cycle delay
	input  wire logic       I_LVD_BELOW,       // detector: supply under threshold
	input  wire logic       I_AUX_BELOW,       // aux comparator: supply low
	input  wire logic       I_WDG_UNDERFLOW,   // watchdog underflow pulse
	input  wire logic       I_HALT,            // cpu in halt state
	input  wire logic       I_WAIT,            // cpu in wait state
	input  wire logic       I_CC_IMASK,        // cpu global interrupt mask
	input  wire logic       I_AUX_ISR_ENTER,   // cpu enters aux isr, pulse
	output logic            O_SYS_RST_N,       // internal reset, low active
	output logic            O_VECTOR_FETCH,    // reset vector fetch phase
	output logic            O_LVD_ACTIVE,      // detector enable to analog
	output logic      [1:0] O_LVD_THR,         // threshold select to analog
	output logic            O_AUX_ACTIVE,      // aux detector enable to analog
	output logic            O_AUX_IRQ,         // aux interrupt request
	output logic            O_WAIT_WAKE        // wake from wait request
);
	// ========================================
	// reset merge
	logic                   pin_oe_q;
	logic                   pin_oe_d;
	logic                   pin_own_q;
	logic                   seq_rst_n;
	logic                   lvd_req;

	// the pin pull-down of our own must not feed back as an external reset
	// mask held one cycle past release: the pin lags our drive and would glitch a reset
	assign seq_rst_n = I_RST_N & (I_RST_PIN_I | pin_oe_q | pin_own_q);
	assign lvd_req   = I_OPT_LVD_EN & I_LVD_BELOW;

	// ========================================
	// reset sequencer
	rsi_pkg::rsi_seq_t      seq_q;
	rsi_pkg::rsi_seq_t      seq_d;
	logic [12:0]            dly_q;
	logic [12:0]            dly_d;
	logic [12:0]            wdg_q;
	logic [12:0]            wdg_d;
	logic [1:0]             fch_q;
	logic [1:0]             fch_d;
	logic                   run_q;
	logic                   run_d;
	logic                   fetch_q;
	logic                   fetch_d;
	logic                   wdg_hit;

	assign wdg_hit = I_WDG_UNDERFLOW & (seq_q == rsi_pkg::SEQ_RUN);

	always_comb begin
		seq_d    = seq_q;
		dly_d    = dly_q;
		fch_d    = fch_q;
		wdg_d    = (wdg_q != 13'h0000) ? wdg_q - 13'h0001 : 13'h0000;
		pin_oe_d = pin_oe_q;
		case (seq_q)
			rsi_pkg::SEQ_ACTIVE: begin
				pin_oe_d = lvd_req | (wdg_q > 13'h0001);
				// own drive runs straight into the delay, so the pin never blips high
				if (!lvd_req && wdg_q <= 13'h0001 && (I_RST_PIN_I || pin_oe_q)) begin
					seq_d    = rsi_pkg::SEQ_DELAY;
					pin_oe_d = 1'b1;
					dly_d    = I_OPT_LONG_DELAY ? rsi_pkg::DELAY_LONG_CYC
					                            : rsi_pkg::DELAY_SHORT_CYC;
				end
			end
			rsi_pkg::SEQ_DELAY: begin
				dly_d = dly_q - 13'h0001;
				if (lvd_req) begin
					seq_d    = rsi_pkg::SEQ_ACTIVE;
				end else if (dly_q == 13'h0001) begin
					seq_d    = rsi_pkg::SEQ_FETCH;
					pin_oe_d = 1'b0;
					fch_d    = rsi_pkg::FETCH_CYC;
				end
			end
			rsi_pkg::SEQ_FETCH: begin
				fch_d = fch_q - 2'h1;
				if (lvd_req) begin
					seq_d    = rsi_pkg::SEQ_ACTIVE;
					pin_oe_d = 1'b1;
				end else if (fch_q == 2'h1) begin
					seq_d = rsi_pkg::SEQ_RUN;
				end
			end
			rsi_pkg::SEQ_RUN: begin
				if (lvd_req || wdg_hit) begin
					seq_d    = rsi_pkg::SEQ_ACTIVE;
					pin_oe_d = 1'b1;
				end
				if (wdg_hit) begin
					wdg_d = rsi_pkg::WDG_CNT_LOAD;
				end
			end
			default: begin
				seq_d = rsi_pkg::SEQ_ACTIVE;
			end
		endcase
		run_d   = (seq_d == rsi_pkg::SEQ_RUN);
		fetch_d = (seq_d == rsi_pkg::SEQ_FETCH);
	end

	// external pin low resets this group at once, clock or not
	always_ff @(posedge I_SYS_CLK or negedge seq_rst_n) begin
		if (!seq_rst_n) begin
			seq_q    <= rsi_pkg::SEQ_ACTIVE;
			dly_q    <= 13'h0000;
			fch_q    <= 2'h0;
			wdg_q    <= 13'h0000;
			pin_oe_q <= 1'b0;
			run_q    <= 1'b0;
			fetch_q  <= 1'b0;
		end else begin
			seq_q    <= seq_d;
			dly_q    <= dly_d;
			fch_q    <= fch_d;
			wdg_q    <= wdg_d;
			pin_oe_q <= pin_oe_d;
			run_q    <= run_d;
			fetch_q  <= fetch_d;
		end
	end

	// ========================================
	// supply integrity register and aux interrupt
	logic                   irq_en_q;
	logic                   irq_en_d;
	logic                   aux_flag_q;
	logic                   aux_flag_d;
	logic                   lv_cause_q;
	logic                   lv_cause_d;
	logic                   wd_cause_q;
	logic                   wd_cause_d;
	logic                   pend_q;
	logic                   pend_d;
	logic                   irq_q;
	logic                   irq_d;
	logic                   wake_q;
	logic                   wake_d;
	logic                   reg_wr;
	logic                   in_reset;

	function automatic logic is_sics(input logic [7:0] addr);
		is_sics = (addr == rsi_pkg::SICS_OFFSET);
	endfunction : is_sics

	assign reg_wr   = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE & is_sics(I_PADDR);
	assign in_reset = (seq_q != rsi_pkg::SEQ_RUN);

	always_comb begin
		irq_en_d   = irq_en_q;
		aux_flag_d = I_OPT_LVD_EN & I_AUX_BELOW;
		lv_cause_d = lv_cause_q;
		wd_cause_d = wd_cause_q;
		pend_d     = pend_q;
		// bits 7 and 3:1 are ignored on write and read as zero
		if (reg_wr) begin
			irq_en_d = I_PWDATA[rsi_pkg::BIT_IRQ_EN];
			if (!I_PWDATA[rsi_pkg::BIT_LV_CAUSE]) begin
				lv_cause_d = 1'b0;
			end
			if (!I_PWDATA[rsi_pkg::BIT_WD_CAUSE]) begin
				wd_cause_d = 1'b0;
			end
		end
		if (I_AUX_ISR_ENTER) begin
			pend_d = 1'b0;
		end
		// toggles latch even while disabled, so enabling exposes them
		if (aux_flag_d != aux_flag_q) begin
			pend_d = 1'b1;
		end
		// toggles during the reset delay are dropped
		if (in_reset) begin
			pend_d = 1'b0;
		end
		if (wdg_hit) begin
			wd_cause_d = 1'b1;
		end
		// external and watchdog resets leave this one alone
		if (lvd_req) begin
			lv_cause_d = 1'b1;
			wd_cause_d = 1'b0;
		end
		if (I_HALT) begin
			irq_en_d   = irq_en_q;
			aux_flag_d = aux_flag_q;
			lv_cause_d = lv_cause_q;
			wd_cause_d = wd_cause_q;
			pend_d     = pend_q;
		end
		irq_d  = pend_d & irq_en_d & ~I_CC_IMASK & ~in_reset;
		// halt is left only by other sources
		wake_d = pend_d & irq_en_d & I_WAIT & ~I_HALT;
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			irq_en_q   <= 1'b0;
			aux_flag_q <= 1'b0;
			lv_cause_q <= 1'b0;
			wd_cause_q <= 1'b0;
			pend_q     <= 1'b0;
			irq_q      <= 1'b0;
			wake_q     <= 1'b0;
		end else begin
			irq_en_q   <= irq_en_d;
			aux_flag_q <= aux_flag_d;
			lv_cause_q <= lv_cause_d;
			wd_cause_q <= wd_cause_d;
			pend_q     <= pend_d;
			irq_q      <= irq_d;
			wake_q     <= wake_d;
		end
	end

	// ========================================
	// apb slave, one wait state
	logic                   rdy_q;
	logic                   rdy_d;
	logic                   err_q;
	logic                   err_d;
	logic [31:0]            rdata_q;
	logic [31:0]            rdata_d;
	logic [7:0]             sics_val;

	assign sics_val = {1'b0, irq_en_q, aux_flag_q, lv_cause_q, 3'h0, wd_cause_q};

	always_comb begin
		rdy_d   = I_PSEL & I_PENABLE & ~rdy_q;
		err_d   = 1'b0;
		rdata_d = rdata_q;
		if (rdy_d) begin
			err_d   = ~is_sics(I_PADDR);
			rdata_d = (!I_PWRITE && is_sics(I_PADDR)) ? {24'h000000, sics_val} : 32'h00000000;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rdy_q   <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			rdy_q   <= rdy_d;
			err_q   <= err_d;
			rdata_q <= rdata_d;
		end
	end

	// ========================================
	// static outputs
	logic                   lvd_act_q;
	logic [1:0]             lvd_thr_q;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			lvd_act_q <= 1'b0;
			lvd_thr_q <= 2'h0;
			pin_own_q <= 1'b0;
		end else begin
			pin_own_q <= pin_oe_q;
			lvd_act_q <= I_OPT_LVD_EN;
			lvd_thr_q <= I_OPT_LVD_THR;
		end
	end

	assign O_PRDATA       = rdata_q;
	assign O_PREADY       = rdy_q;
	assign O_PSLVERR      = err_q;
	assign O_RST_PIN_O    = 1'b0;
	assign O_RST_PIN_OE   = pin_oe_q;
	assign O_SYS_RST_N    = run_q;
	assign O_VECTOR_FETCH = fetch_q;
	assign O_LVD_ACTIVE   = lvd_act_q;
	assign O_LVD_THR      = lvd_thr_q;
	assign O_AUX_ACTIVE   = lvd_act_q;
	assign O_AUX_IRQ      = irq_q;
	assign O_WAIT_WAKE    = wake_q;
endmodule : rsi_top

`default_nettype wire

// file: sim/rsi_pin_model.sv
// board side of the reset pin: pull-up, outside reset circuit and device drive
`timescale 1ns/1ps
`default_nettype none

module rsi_pin_model (
	input  wire logic i_oe,      // device pull-down enable
	input  wire logic i_o,       // device drive value
	input  wire logic i_ext_low, // outside circuit pulls low
	output logic      o_pin      // resolved pin level
);
	// weak pull-up wins only when nobody pulls; the device can only pull low
	assign o_pin = ((i_oe && !i_o) || i_ext_low) ? 1'b0 : 1'b1;
endmodule : rsi_pin_model

`default_nettype wire

// file: sim/rsi_top_assertions.sv
// concurrent checks on the ports of the reset and supply integrity block
`timescale 1ns/1ps
`default_nettype none

module rsi_top_assertions (
	input wire logic        I_SYS_CLK,       // clock
	input wire logic        I_RST_N,         // reset
	input wire logic        I_PSEL,          // select
	input wire logic        I_PENABLE,       // enable
	input wire logic [7:0]  I_PADDR,         // address
	input wire logic [31:0] O_PRDATA,        // read data
	input wire logic        O_PREADY,        // ready
	input wire logic        O_PSLVERR,       // error
	input wire logic        I_RST_PIN_I,     // pin level
	input wire logic        O_RST_PIN_O,     // pin value
	input wire logic        O_RST_PIN_OE,    // pin drive
	input wire logic        I_OPT_LVD_EN,    // detector option
	input wire logic        I_LVD_BELOW,     // supply low
	input wire logic        I_WDG_UNDERFLOW, // watchdog
	input wire logic        I_HALT,          // halt
	input wire logic        I_CC_IMASK,      // cpu mask
	input wire logic        O_SYS_RST_N,     // internal reset
	input wire logic        O_VECTOR_FETCH,  // fetch
	input wire logic        O_AUX_ACTIVE,    // aux enable
	input wire logic        O_AUX_IRQ,       // irq
	input wire logic        O_WAIT_WAKE      // wake
);
	// ========================================
	// run length of pin drive
	int unsigned oe_run_q;
	int unsigned oe_run_d;
	always_comb begin
		oe_run_d = O_RST_PIN_OE ? oe_run_q + 1 : 0;
	end
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			oe_run_q <= 0;
		end else begin
			oe_run_q <= oe_run_d;
		end
	end

	// ========================================
	// properties
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_N);
	sequence s_setup; I_PSEL && !I_PENABLE; endsequence
	sequence s_answer; !O_PREADY ##1 O_PREADY; endsequence
	sequence s_fetch; O_VECTOR_FETCH ##1 O_VECTOR_FETCH ##1 (!O_VECTOR_FETCH && O_SYS_RST_N); endsequence
	property p_apb_wait; s_setup |=> s_answer; endproperty
	property p_apb_err; O_PREADY |-> (O_PSLVERR == (I_PADDR != 8'h00)) && (!O_PSLVERR || O_PRDATA == 32'h0); endproperty
	property p_pin_val; O_RST_PIN_O == 1'b0; endproperty
	property p_ext; !I_RST_PIN_I && !O_RST_PIN_OE |-> !O_SYS_RST_N; endproperty
	property p_lvd; I_OPT_LVD_EN && I_LVD_BELOW |=> O_RST_PIN_OE && !O_SYS_RST_N; endproperty
	property p_wdg; I_WDG_UNDERFLOW && O_SYS_RST_N |=> O_RST_PIN_OE && !O_SYS_RST_N; endproperty
	property p_delay; $fell(O_RST_PIN_OE) |-> oe_run_q >= 256; endproperty
	property p_fetch; $fell(O_RST_PIN_OE) && !O_SYS_RST_N |-> s_fetch; endproperty
	property p_aux_off; !I_OPT_LVD_EN |=> !O_AUX_ACTIVE; endproperty
	property p_mask; I_CC_IMASK |=> !O_AUX_IRQ; endproperty
	property p_halt; I_HALT |=> !O_WAIT_WAKE; endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("ready not after one wait state");
	a_apb_err: assert property (p_apb_err) else $error("error response does not match address");
	a_pin_val: assert property (p_pin_val) else $error("pin drive value not low");
	a_ext: assert property (p_ext) else $error("outside pin low without internal reset");
	a_lvd: assert property (p_lvd) else $error("low supply without pin drive");
	a_wdg: assert property (p_wdg) else $error("underflow without pin drive");
	a_delay: assert property (p_delay) else $error("pin drive shorter than delay");
	a_fetch: assert property (p_fetch) else $error("fetch phase not two cycles");
	a_aux_off: assert property (p_aux_off) else $error("aux detector on with detector off");
	a_mask: assert property (p_mask) else $error("irq while cpu mask set");
	a_halt: assert property (p_halt) else $error("wake while halted");
endmodule : rsi_top_assertions

`default_nettype wire

// file: sim/rsi_top_tb.sv
// self-checking testbench for the reset and supply integrity block
`timescale 1ns/1ps
`default_nettype none

module rsi_top_tb;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] wd; logic [31:0] exp; logic err;} rsi_row_t;
	// unmapped write must leave bit 6 standing for the read that follows
	localparam rsi_row_t ROWS [5] = '{'{1'b1, 8'h00, 32'h71, 32'h40, 1'b0}, '{1'b1, 8'h04, 32'h0, 32'h0, 1'b1},
		'{1'b0, 8'h00, 32'h0, 32'h40, 1'b0}, '{1'b1, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b1, 8'h80, 32'hff, 32'h0, 1'b1}};
	logic        clk, rst_n, psel, pen, pwr, opt_en, long_dly, lvd_below, aux_below, wdg, halt, wt, imask, isr;
	logic        ext_low, err, rdy, slverr, pin, pin_o, oe, sys_rst_n, fetch, lvd_act, aux_act, irq, wake;
	logic [1:0]  thr, lvd_thr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          error_cnt, checks, n;

	rsi_top i_dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(rdy), .O_PSLVERR(slverr),
		.I_RST_PIN_I(pin), .O_RST_PIN_O(pin_o), .O_RST_PIN_OE(oe), .I_OPT_LVD_EN(opt_en), .I_OPT_LVD_THR(thr),
		.I_OPT_LONG_DELAY(long_dly), .I_LVD_BELOW(lvd_below), .I_AUX_BELOW(aux_below), .I_WDG_UNDERFLOW(wdg),
		.I_HALT(halt), .I_WAIT(wt), .I_CC_IMASK(imask), .I_AUX_ISR_ENTER(isr), .O_SYS_RST_N(sys_rst_n),
		.O_VECTOR_FETCH(fetch), .O_LVD_ACTIVE(lvd_act), .O_LVD_THR(lvd_thr), .O_AUX_ACTIVE(aux_act),
		.O_AUX_IRQ(irq), .O_WAIT_WAKE(wake));
	rsi_pin_model i_pin (.i_oe(oe), .i_o(pin_o), .i_ext_low(ext_low), .o_pin(pin));

	// ========================================
	// tasks
	task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk32
	task automatic chk1(input string nm, input logic exp, input logic got);
		chk32(nm, {31'h0, exp}, {31'h0, got});
	endtask : chk1
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
	endtask : tick
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d, output logic e);
		@(posedge clk);
		{psel, pwr, paddr, pwdata} <= {1'b1, wr, a, wd};
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		d = prdata;
		e = slverr;
		{psel, pen} <= 2'b00;
	endtask : apb
	task automatic rd_chk(input string nm, input logic [31:0] exp);
		apb(1'b0, 8'h00, 32'h0, rd, err);
		chk32(nm, exp, rd);
	endtask : rd_chk
	// counts pin drive cycles until the cpu runs; the watchdog cuts a hang
	task automatic wait_run(output int cnt);
		cnt = 0;
		while (sys_rst_n !== 1'b1) begin
			@(posedge clk);
			if (oe === 1'b1) cnt++;
		end
	endtask : wait_run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	// ========================================
	// clock, watchdog, main sequence
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
	initial begin
		{rst_n, psel, pen, pwr, long_dly, lvd_below, aux_below, wdg, halt, wt, imask, isr, ext_low} = '0;
		{opt_en, thr, paddr, pwdata} = {1'b1, 2'h1, 8'h00, 32'h0};
		tick(12);
		rst_n <= 1'b1;
		wait_run(n);
		chk1("power-on delay", 1'b1, n >= 256 && n <= 262);
		rd_chk("reset value", 32'h0);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			apb(ROWS[i].wr, ROWS[i].a, ROWS[i].wd, rd, err);
			apb(1'b0, ROWS[i].a, 32'h0, rd, err);
			chk32("register", ROWS[i].exp, rd);
			chk1("slave error", ROWS[i].err, err);
		end
		$display("test register rows done");
		aux_below <= 1'b1;
		tick(6);
		chk1("irq disabled", 1'b0, irq);
		apb(1'b1, 8'h00, 32'h40, rd, err);
		tick(3);
		chk1("irq on enable", 1'b1, irq);
		rd_chk("aux flag", 32'h60);
		isr <= 1'b1;
		tick(1);
		isr <= 1'b0;
		tick(3);
		chk1("irq after isr", 1'b0, irq);
		{aux_below, imask, wt} <= 3'b011;
		tick(6);
		chk1("irq masked", 1'b0, irq);
		chk1("wait wake", 1'b1, wake);
		imask <= 1'b0;
		tick(3);
		chk1("irq on rise", 1'b1, irq);
		halt <= 1'b1;
		apb(1'b1, 8'h00, 32'h0, rd, err);
		chk1("halt wake", 1'b0, wake);
		{halt, wt, isr} <= 3'b001;
		rd_chk("halt freeze", 32'h40);
		isr <= 1'b0;
		apb(1'b1, 8'h00, 32'h0, rd, err);
		$display("test aux interrupt done");
		wdg <= 1'b1;
		tick(1);
		wdg <= 1'b0;
		tick(1);
		chk1("watchdog drive", 1'b1, oe);
		wait_run(n);
		chk1("watchdog length", 1'b1, n >= rsi_pkg::WDG_PULSE_CYC + 250 && n <= rsi_pkg::WDG_PULSE_CYC + 262);
		rd_chk("watchdog cause", 32'h01);
		apb(1'b1, 8'h00, 32'h41, rd, err);
		$display("test watchdog done");
		{long_dly, lvd_below} <= 2'b11;
		tick(2);
		aux_below <= 1'b1;
		tick(28);
		{lvd_below, aux_below} <= 2'b00;
		wait_run(n);
		chk1("low supply length", 1'b1, n >= 4096 && n <= 4096 + 6);
		tick(2);
		chk1("no irq after delay", 1'b0, irq);
		rd_chk("low supply cause", 32'h50);
		{long_dly, ext_low} <= 2'b01;
		tick(2);
		chk1("outside reset", 1'b0, sys_rst_n);
		ext_low <= 1'b0;
		wait_run(n);
		chk1("outside length", 1'b1, n >= 250 && n <= 262);
		rd_chk("cause kept", 32'h50);
		apb(1'b1, 8'h00, 32'h0, rd, err);
		rd_chk("cause cleared", 32'h0);
		$display("test reset causes done");
		for (int t = 0; t < 3; t++) begin
			thr <= 2'(t);
			tick(3);
			chk32("threshold", 32'(t), {30'h0, lvd_thr});
			chk1("detector on", 1'b1, lvd_act);
		end
		{opt_en, aux_below} <= 2'b01;
		tick(3);
		chk1("detector off", 1'b0, lvd_act);
		chk1("aux off", 1'b0, aux_act);
		apb(1'b0, 8'h00, 32'h0, rd, err);
		chk32("aux flag off", 32'h0, rd & 32'h20);
		$display("test options done");
		stop_test();
	end
endmodule : rsi_top_tb

bind rsi_top rsi_top_assertions i_chk (.I_SYS_CLK, .I_RST_N, .I_PSEL, .I_PENABLE, .I_PADDR, .O_PRDATA, .O_PREADY,
	.O_PSLVERR, .I_RST_PIN_I, .O_RST_PIN_O, .O_RST_PIN_OE, .I_OPT_LVD_EN, .I_LVD_BELOW, .I_WDG_UNDERFLOW, .I_HALT,
	.I_CC_IMASK, .O_SYS_RST_N, .O_VECTOR_FETCH, .O_AUX_ACTIVE, .O_AUX_IRQ, .O_WAIT_WAKE);

`default_nettype wire
